// ===== asp_pkg.sv
// Shared constants, register map and types of the serial port and its peer.
package asp_pkg;
	// Register indices; byte address is four times the index.
	localparam logic [9:0] IDX_CTRL = 10'h098;
	localparam logic [9:0] IDX_DATA = 10'h099;
	localparam logic [9:0] IDX_CFG = 10'h09A;
	localparam logic [9:0] IDX_SET = 10'h09B;
	localparam logic [9:0] IDX_CLR = 10'h09C;
	// Control register bit positions.
	localparam int B_MODE = 7;
	localparam int B_MCE = 5;
	localparam int B_REN = 4;
	localparam int B_TB8 = 3;
	localparam int B_RB8 = 2;
	localparam int B_TI = 1;
	localparam int B_RI = 0;
	localparam logic [7:0] UNUSED_MASK = 8'h40;
	localparam logic [7:0] CTRL_RESET = 8'h40;
	// Configuration register bit positions.
	localparam int CFG_RUN = 8;
	localparam int CFG_IE = 9;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] TIMER_TOP = 8'hFF;
	// Frame lengths in bit times and index of the last data bit.
	localparam logic [3:0] BITS_8MODE = 4'hA;
	localparam logic [3:0] BITS_9MODE = 4'hB;
	localparam logic [3:0] LAST_DATA_8 = 4'h7;
	localparam logic [3:0] LAST_DATA_9 = 4'h8;
	typedef enum logic [1:0] {
		ASP_RX_IDLE = 2'b00,
		ASP_RX_START = 2'b01,
		ASP_RX_DATA = 2'b11,
		ASP_RX_STOP = 2'b10
	} asp_rx_state_type;
	// Builds a frame sent from bit 0 upward: start, data LSB first, ninth bit or stop, stop.
	function automatic logic [10:0] asp_frame(input logic nine, input logic ninth, input logic [7:0] data);
		asp_frame = {1'b1, nine ? ninth : 1'b1, data, 1'b0};
	endfunction
endpackage

// ===== asp_link_if.sv
// Serial link between the port and its peer.
`timescale 1ns/1ps
interface asp_link_if;
	logic serial_out_pin;
	logic serial_in_pin;
	modport dev_mp (output serial_out_pin, input serial_in_pin);
	modport peer_mp (input serial_out_pin, output serial_in_pin);
endinterface

// ===== asp_device.sv
// Serial port with multiprocessor filtering behind an APB register slave.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module asp_device (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out,
	asp_link_if.dev_mp link
);
	// The whole port state; one process builds the next copy and one registers it.
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] rbuf;
		logic [7:0] reload;
		logic run;
		logic ie;
		logic [7:0] txc;
		logic txh;
		logic [10:0] txs;
		logic [3:0] txn;
		logic txo;
		logic [7:0] rxc;
		logic rxh;
		asp_pkg::asp_rx_state_type rxst;
		logic [3:0] rxn;
		logic [8:0] rxs;
		logic [1:0] sync;
		logic prev;
		logic [31:0] rdata;
	} asp_dev_state_type;

	asp_dev_state_type r_reg;
	asp_dev_state_type r_next;
	logic [9:0] idx;
	logic hit;
	logic wr;
	logic nine;
	logic tx_ovf;
	logic tx_tick;
	logic rx_ovf;
	logic rx_samp;
	logic din;
	logic fall;
	logic [7:0] rx_byte;
	logic rx_ninth;

	assign idx = paddr_in[11:2];
	// Only the five registers of the port answer without an error.
	assign hit = idx == asp_pkg::IDX_CTRL || idx == asp_pkg::IDX_DATA || idx == asp_pkg::IDX_CFG
		|| idx == asp_pkg::IDX_SET || idx == asp_pkg::IDX_CLR;
	assign wr = psel_in && penable_in && pwrite_in && hit;
	assign nine = r_reg.ctrl[asp_pkg::B_MODE];
	// Both baud timers overflow at the top count and reload from the shared reload value.
	assign tx_ovf = r_reg.run && r_reg.txc == asp_pkg::TIMER_TOP;
	assign tx_tick = tx_ovf && r_reg.txh;
	assign rx_ovf = r_reg.run && r_reg.rxc == asp_pkg::TIMER_TOP;
	assign rx_samp = rx_ovf && !r_reg.rxh;
	assign din = r_reg.sync[1];
	// A start is the first low sample after a high one on the synchronised line.
	assign fall = r_reg.prev && !din;
	// In 9-bit frames the byte sits below the ninth bit; in 8-bit frames it fills the top eight.
	assign rx_byte = nine ? r_reg.rxs[7:0] : r_reg.rxs[8:1];
	// In 8-bit mode the stop bit takes the ninth bit's place; in 9-bit mode the stop is ignored.
	assign rx_ninth = nine ? r_reg.rxs[8] : din;

	assign prdata_out = r_reg.rdata;
	// Every access completes at once; an unmapped one answers with an error.
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in && !hit;
	// The request stands as long as either flag is set, since only software clears them.
	assign irq_out = r_reg.ie && (r_reg.ctrl[asp_pkg::B_TI] || r_reg.ctrl[asp_pkg::B_RI]);
	assign link.serial_out_pin = r_reg.txo;

	always_comb begin
		r_next = r_reg;
		r_next.sync = {r_reg.sync[0], link.serial_in_pin};
		r_next.prev = r_reg.sync[1];
		// Read data is captured in the setup cycle so it stands through the access cycle.
		if (psel_in && !penable_in) begin
			unique case (idx)
				asp_pkg::IDX_CTRL: r_next.rdata = {24'h00_0000, r_reg.ctrl};
				asp_pkg::IDX_DATA: r_next.rdata = {24'h00_0000, r_reg.rbuf};
				asp_pkg::IDX_CFG: r_next.rdata = {22'h00_0000, r_reg.ie, r_reg.run, r_reg.reload};
				default: r_next.rdata = 32'h0000_0000;
			endcase
		end
		// Software writes come first so that hardware sets below win over a clear.
		if (wr) begin
			unique case (idx)
				asp_pkg::IDX_CTRL: r_next.ctrl = pwdata_in[7:0];
				asp_pkg::IDX_SET: r_next.ctrl = r_reg.ctrl | pwdata_in[7:0];
				asp_pkg::IDX_CLR: r_next.ctrl = r_reg.ctrl & ~pwdata_in[7:0];
				asp_pkg::IDX_CFG: begin
					r_next.reload = pwdata_in[7:0];
					r_next.run = pwdata_in[asp_pkg::CFG_RUN];
					r_next.ie = pwdata_in[asp_pkg::CFG_IE];
				end
				default: begin
					// A write while a frame is still going out is dropped.
					if (r_reg.txn == 4'h0) begin
						r_next.txs = asp_pkg::asp_frame(nine, r_reg.ctrl[asp_pkg::B_TB8], pwdata_in[7:0]);
						r_next.txn = nine ? asp_pkg::BITS_9MODE : asp_pkg::BITS_8MODE;
					end
				end
			endcase
			r_next.ctrl = (r_next.ctrl & ~asp_pkg::UNUSED_MASK) | asp_pkg::UNUSED_MASK;
		end
		// Transmit timer runs free; every second overflow is one bit time.
		if (r_reg.run) begin
			r_next.txc = tx_ovf ? r_reg.reload : r_reg.txc + 8'h01;
			r_next.txh = r_reg.txh ^ tx_ovf;
		end
		// The frame leaves from bit 0; ones refill the top so the line rests high afterwards.
		if (tx_tick && r_reg.txn != 4'h0) begin
			r_next.txo = r_reg.txs[0];
			r_next.txs = {1'b1, r_reg.txs[10:1]};
			r_next.txn = r_reg.txn - 4'h1;
			if (r_reg.txn == 4'h1) begin
				r_next.ctrl[asp_pkg::B_TI] = 1'b1;
			end
		end
		// The receive timer is a private copy of the transmit timer that a start may restart.
		if (r_reg.run) begin
			r_next.rxc = rx_ovf ? r_reg.reload : r_reg.rxc + 8'h01;
			r_next.rxh = r_reg.rxh ^ rx_ovf;
		end
		unique case (r_reg.rxst)
			asp_pkg::ASP_RX_IDLE: begin
				if (r_reg.ctrl[asp_pkg::B_REN] && fall) begin
					// Restarting the timer puts the first sample half a bit after the edge.
					r_next.rxc = r_reg.reload;
					r_next.rxh = 1'b0;
					r_next.rxst = asp_pkg::ASP_RX_START;
				end
			end
			asp_pkg::ASP_RX_START: begin
				if (rx_samp) begin
					r_next.rxn = 4'h0;
					// A start that is high again at mid-bit was a glitch and is dropped.
					r_next.rxst = din ? asp_pkg::ASP_RX_IDLE : asp_pkg::ASP_RX_DATA;
				end
			end
			asp_pkg::ASP_RX_DATA: begin
				if (rx_samp) begin
					// Bits arrive least significant first and shift down from the top.
					r_next.rxs = {din, r_reg.rxs[8:1]};
					r_next.rxn = r_reg.rxn + 4'h1;
					if (r_reg.rxn == (nine ? asp_pkg::LAST_DATA_9 : asp_pkg::LAST_DATA_8)) begin
						r_next.rxst = asp_pkg::ASP_RX_STOP;
					end
				end
			end
			asp_pkg::ASP_RX_STOP: begin
				if (rx_samp) begin
					r_next.rxst = asp_pkg::ASP_RX_IDLE;
					// A full buffer or a character filtered out for a clear ninth bit leaves everything as it was.
					if (!r_reg.ctrl[asp_pkg::B_RI] && (!r_reg.ctrl[asp_pkg::B_MCE] || rx_ninth)) begin
						r_next.rbuf = rx_byte;
						r_next.ctrl[asp_pkg::B_RB8] = rx_ninth;
						r_next.ctrl[asp_pkg::B_RI] = 1'b1;
					end
				end
			end
		endcase
	end

	// Reset fills the synchroniser with ones, so no false start follows it.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			r_reg <= '0;
			r_reg.ctrl <= asp_pkg::CTRL_RESET;
			r_reg.reload <= asp_pkg::RELOAD_RESET;
			r_reg.txo <= 1'b1;
			r_reg.sync <= 2'b11;
			r_reg.prev <= 1'b1;
			r_reg.rxst <= asp_pkg::ASP_RX_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule // asp_device

// ===== asp_peer.sv
// Far-end serial port that exchanges frames with the device over the link.
`timescale 1ns/1ps
module asp_peer (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic nine_bit_in,
	input wire logic [7:0] reload_in,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_ninth_in,
	output logic tx_ready_out,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic rx_ninth_out,
	asp_link_if.peer_mp link
);
	typedef struct packed {
		logic [7:0] txc;
		logic txh;
		logic [10:0] txs;
		logic [3:0] txn;
		logic txo;
		logic [7:0] rxc;
		logic rxh;
		asp_pkg::asp_rx_state_type rxst;
		logic [3:0] rxn;
		logic [8:0] rxs;
		logic [1:0] sync;
		logic prev;
		logic rxv;
		logic [7:0] rxd;
		logic rx9;
	} asp_peer_state_type;

	asp_peer_state_type r_reg;
	asp_peer_state_type r_next;
	logic tx_ovf;
	logic rx_ovf;
	logic rx_samp;
	logic din;

	assign tx_ovf = r_reg.txc == asp_pkg::TIMER_TOP;
	assign rx_ovf = r_reg.rxc == asp_pkg::TIMER_TOP;
	assign rx_samp = rx_ovf && !r_reg.rxh;
	assign din = r_reg.sync[1];
	assign tx_ready_out = r_reg.txn == 4'h0;
	assign rx_valid_out = r_reg.rxv;
	assign rx_data_out = r_reg.rxd;
	assign rx_ninth_out = r_reg.rx9;
	assign link.serial_in_pin = r_reg.txo;

	always_comb begin
		r_next = r_reg;
		r_next.sync = {r_reg.sync[0], link.serial_out_pin};
		r_next.prev = r_reg.sync[1];
		r_next.rxv = 1'b0;
		r_next.txc = tx_ovf ? reload_in : r_reg.txc + 8'h01;
		r_next.txh = r_reg.txh ^ tx_ovf;
		if (tx_valid_in && r_reg.txn == 4'h0) begin
			// The ninth bit marks an address character when set.
			r_next.txs = asp_pkg::asp_frame(nine_bit_in, tx_ninth_in, tx_data_in);
			r_next.txn = nine_bit_in ? asp_pkg::BITS_9MODE : asp_pkg::BITS_8MODE;
		end else if (tx_ovf && r_reg.txh && r_reg.txn != 4'h0) begin
			r_next.txo = r_reg.txs[0];
			r_next.txs = {1'b1, r_reg.txs[10:1]};
			r_next.txn = r_reg.txn - 4'h1;
		end
		r_next.rxc = rx_ovf ? reload_in : r_reg.rxc + 8'h01;
		r_next.rxh = r_reg.rxh ^ rx_ovf;
		unique case (r_reg.rxst)
			asp_pkg::ASP_RX_IDLE: begin
				if (r_reg.prev && !din) begin
					r_next.rxc = reload_in;
					r_next.rxh = 1'b0;
					r_next.rxst = asp_pkg::ASP_RX_START;
				end
			end
			asp_pkg::ASP_RX_START: begin
				if (rx_samp) begin
					r_next.rxn = 4'h0;
					r_next.rxst = din ? asp_pkg::ASP_RX_IDLE : asp_pkg::ASP_RX_DATA;
				end
			end
			asp_pkg::ASP_RX_DATA: begin
				if (rx_samp) begin
					r_next.rxs = {din, r_reg.rxs[8:1]};
					r_next.rxn = r_reg.rxn + 4'h1;
					if (r_reg.rxn == (nine_bit_in ? asp_pkg::LAST_DATA_9 : asp_pkg::LAST_DATA_8)) begin
						r_next.rxst = asp_pkg::ASP_RX_STOP;
					end
				end
			end
			asp_pkg::ASP_RX_STOP: begin
				if (rx_samp) begin
					r_next.rxst = asp_pkg::ASP_RX_IDLE;
					r_next.rxv = 1'b1;
					r_next.rxd = nine_bit_in ? r_reg.rxs[7:0] : r_reg.rxs[8:1];
					r_next.rx9 = nine_bit_in ? r_reg.rxs[8] : din;
				end
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			r_reg <= '0;
			r_reg.txo <= 1'b1;
			r_reg.sync <= 2'b11;
			r_reg.prev <= 1'b1;
			r_reg.rxst <= asp_pkg::ASP_RX_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule // asp_peer

// ===== asp_link_chk.sv
// Assertions on the serial link, the peer handshake and the register bus answer.
`timescale 1ns/1ps
module asp_link_chk #(parameter int BIT_CLKS = 4) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic serial_out_pin,
	input wire logic serial_in_pin,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_in,
	input wire logic pslverr_in,
	input wire logic tx_valid_in,
	input wire logic tx_ready_in
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	logic [7:0] low_run_reg;
	// Counts consecutive low samples of the device line; a missing stop bit makes it run on.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || serial_out_pin) begin
			low_run_reg <= 8'h00;
		end else begin
			low_run_reg <= low_run_reg + 8'h01;
		end
	end
	out_reset_idle_a: assert property (disable iff (1'b0) sys_rst_in |=> serial_out_pin && serial_in_pin)
		else $error("serial lines not idle high after reset");
	// The bit checks below assume four clocks to a bit.
	tx_bit_width_a: assert property ($changed(serial_out_pin) |=> $stable(serial_out_pin)[*3])
		else $error("device bit shorter than one bit time");
	rx_bit_width_a: assert property ($changed(serial_in_pin) |=> $stable(serial_in_pin)[*3])
		else $error("peer bit shorter than one bit time");
	low_run_bound_a: assert property (low_run_reg <= 8'(10 * BIT_CLKS))
		else $error("device line low longer than a frame allows");
	ready_const_a: assert property (psel_in |-> pready_in)
		else $error("bus answer not ready at once");
	slverr_access_a: assert property (pslverr_in |-> psel_in && penable_in)
		else $error("error response outside an access cycle");
	peer_busy_a: assert property (tx_valid_in && tx_ready_in |=> !tx_ready_in)
		else $error("peer still ready after taking a byte");
	peer_idle_line_a: assert property (tx_ready_in |-> serial_in_pin)
		else $error("peer line low while peer idle");
endmodule // asp_link_chk

// ===== async_serial_port_multiproc_tb.sv
// Self-checking bench: the port and its peer joined over the serial link.
`timescale 1ns/1ps
module async_serial_port_multiproc_tb;
	logic clock_in, sys_rst_in, psel, penable, pwrite, pready, pslverr, irq;
	logic tx_valid, tx_ninth, nine, tx_ready, rx_valid, rx_ninth, rb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_val;
	logic [7:0] tx_data, rx_data, c, d, dexp;
	logic [4:0] r;
	logic [35:0] e;
	logic [35:0] rq[$];
	logic [1:0] iq = 2'b00;
	logic [8:0] pq[$];
	logic [7:0] tx_mode[3] = '{8'h40, 8'hC0, 8'hC8};
	// Columns: mode, filter, receive enable, done flag before, ninth bit sent.
	logic [4:0] rx_case[6] = '{5'b11100, 5'b11101, 5'b10110, 5'b10100, 5'b10001, 5'b01101};
	int failures = 0;
	int cmp_count = 0;
	asp_link_if link ();
	asp_device asp_device_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .irq_out(irq), .link(link.dev_mp));
	asp_peer asp_peer_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .nine_bit_in(nine), .reload_in(8'hFE),
		.tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ninth_in(tx_ninth), .tx_ready_out(tx_ready),
		.rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_ninth_out(rx_ninth), .link(link.peer_mp));
	asp_link_chk #(.BIT_CLKS(4)) asp_link_chk_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.serial_out_pin(link.serial_out_pin), .serial_in_pin(link.serial_in_pin), .psel_in(psel),
		.penable_in(penable), .pready_in(pready), .pslverr_in(pslverr), .tx_valid_in(tx_valid),
		.tx_ready_in(tx_ready));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Each transfer notes: irq compared, irq expected, error expected, word compared, expected word.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic ck);
		rq.push_back({iq, a[11:2] < asp_pkg::IDX_CTRL || a[11:2] > asp_pkg::IDX_CLR, ck && !w, v});
		iq = 2'b00;
		@(posedge clock_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clock_in);
		penable <= 1'b1;
		@(posedge clock_in);
		while (pready !== 1'b1) @(posedge clock_in);
		rd_val = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic peer_send(input logic [7:0] v, input logic n);
		@(posedge clock_in);
		tx_valid <= 1'b1;
		tx_data <= v;
		tx_ninth <= n;
		@(posedge clock_in);
		while (tx_ready !== 1'b1) @(posedge clock_in);
		tx_valid <= 1'b0;
		@(posedge clock_in);
		while (tx_ready !== 1'b1) @(posedge clock_in);
		repeat (8) @(posedge clock_in);
	endtask
	always @(posedge clock_in) begin
		if (psel && penable && pready) begin
			e = rq.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[33]});
			if (e[35]) chk({31'h0, irq}, {31'h0, e[34]});
			if (!pwrite && e[32]) chk(prdata, e[31:0]);
		end
		if (rx_valid === 1'b1) begin
			chk({23'h0, rx_ninth, rx_data}, {23'h0, pq.pop_front()});
		end
	end
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	initial begin
		#40000;
		failures++;
		end_of_test();
	end
	initial begin
		{sys_rst_in, psel, penable, pwrite, tx_valid, tx_ninth, nine, rb} = 8'h80;
		{paddr, pwdata, tx_data, dexp} = '0;
		d = 8'($urandom(32'h8672));
		repeat (3) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		apb(1'b0, 12'h260, 32'h0000_0040, 1'b1);
		apb(1'b1, 12'h260, 32'h0000_0000, 1'b0);
		apb(1'b0, 12'h260, 32'h0000_0040, 1'b1);
		apb(1'b0, 12'h3FC, 32'h0000_0000, 1'b1);
		apb(1'b1, 12'h268, 32'h0000_03FE, 1'b0);
		$display("test registers done");
		for (int k = 0; k < 3; k++) begin
			d = 8'($urandom);
			nine <= tx_mode[k][7];
			apb(1'b1, 12'h260, {24'h0, tx_mode[k]}, 1'b0);
			pq.push_back({tx_mode[k][7] ? tx_mode[k][3] : 1'b1, d});
			apb(1'b1, 12'h264, {24'h0, d}, 1'b0);
			rd_val = 32'h0;
			while (!rd_val[1]) apb(1'b0, 12'h260, 32'h0, 1'b0);
			repeat (12) @(posedge clock_in);
			iq = 2'b11;
			apb(1'b0, 12'h260, {24'h0, tx_mode[k] | 8'h02}, 1'b1);
			apb(1'b1, 12'h270, 32'h0000_0002, 1'b0);
			iq = 2'b10;
			apb(1'b0, 12'h260, {24'h0, tx_mode[k]}, 1'b1);
		end
		$display("test transmit done");
		for (int k = 0; k < 6; k++) begin
			d = 8'($urandom);
			r = rx_case[k];
			nine <= r[4];
			c = {r[4], 1'b1, r[3], r[2], 1'b0, rb, 1'b0, r[1]};
			apb(1'b1, 12'h260, {24'h0, c}, 1'b0);
			peer_send(d, r[0]);
			if (r[2] && !r[1] && (!r[3] || r[0] || !r[4])) begin
				dexp = d;
				rb = r[4] ? r[0] : 1'b1;
				c[2] = rb;
				c[0] = 1'b1;
			end
			iq = {1'b1, c[0]};
			apb(1'b0, 12'h260, {24'h0, c}, 1'b1);
			apb(1'b0, 12'h264, {24'h0, dexp}, 1'b1);
		end
		$display("test receive done");
		end_of_test();
	end
endmodule // async_serial_port_multiproc_tb
